// *** plr_consts.svh ***
/*
 Offsets, field positions, reset values and codes for the program level
 register file. Assumes inclusion by the package and the top module.
*/
`ifndef PLR_CONSTS_SVH
`define PLR_CONSTS_SVH

// Geometry
`define PLR_LEVELS      16
`define PLR_SLOTS       10
`define PLR_WORD        16

// Register bus offsets
`define PLR_OFF_CTRL    4'h0
`define PLR_OFF_STATUS  4'h4
`define PLR_OFF_DBG_SEL 4'h8
`define PLR_OFF_DBG_DAT 4'hc

// Control register fields
`define PLR_CTRL_LVL_LO 0
`define PLR_CTRL_MMU    4
`define PLR_CTRL_ERRIE  5
`define PLR_CTRL_RESET  32'h0000_0000

// Indicator positions in the status word
`define PLR_IND_PTM     0
`define PLR_IND_TG      1
`define PLR_IND_K       2
`define PLR_IND_Z       3
`define PLR_IND_Q       4
`define PLR_IND_O       5
`define PLR_IND_C       6
`define PLR_IND_M       7

// Bus answers
`define PLR_RESP_OKAY   2'b00
`define PLR_RESP_SLVERR 2'b10

`endif

// *** plr_pkg.sv ***
/*
 Types for the program level register file.
 Assumes plr_consts.svh sits in the same folder.
*/
package plr_pkg;
	`include "plr_consts.svh"

	// Register select codes: eight general, two scratch, zero source
	typedef enum logic [3:0]
	{
		PLR_STS  = 4'h0,
		PLR_A    = 4'h1,
		PLR_D    = 4'h2,
		PLR_T    = 4'h3,
		PLR_L    = 4'h4,
		PLR_X    = 4'h5,
		PLR_B    = 4'h6,
		PLR_P    = 4'h7,
		PLR_S0   = 4'h8,
		PLR_S1   = 4'h9,
		PLR_ZERO = 4'hf
	} plr_sel_t;

	typedef logic [15:0] plr_word_t;
	typedef logic [3:0]  plr_level_t;
endpackage

// *** plr_regfile.sv ***
/*
 Program level register file: sixteen register sets with indicators,
 address formation and an AXI4-Lite window for control and debug.
 Assumes the microprogram unit drives its strobes synchronous to mclk.
*/
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "plr_consts.svh"
// How it works
// - Sixteen register sets, one per level.
// - Each set holds eight general registers.
// - Two microprogram scratch registers per level.
// - Sixteen-bit path, 32-bit for double, 48-bit for float.
// - Without MMU, logical address drives memory.
// - D extends A; double shifts concatenate.
// - T holds floating exponent part.
// - Subroutine jump loads return address into L.
// - X added after indirect fetch.
// - B added before indirect fetch.
// - P sequences, branches, and transfers freely.
// - Zero pseudo-register for operate and skip.
// - Carry and dynamic overflow follow last operation.
// - Static overflow sticks until program clears.
// - Error sticky, routable to interrupt level.
// - One-bit accumulator for bit operations.
// - Rounding indicator kept for floating point.
// - Multi-shift link catches discarded shift bits.
// - Page table mode enables alternate table.
// - Indicators set singly or moved with A.
// - Two-address fields map to three-address fields.
module plr_regfile
(
	input  wire logic                mclk,
	input  wire logic                nrst,
	input  wire logic [3:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [3:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire logic                level_load,
	input  wire plr_pkg::plr_level_t level_in,
	input  wire logic                ir_map,
	input  wire plr_pkg::plr_word_t  instr_word,
	input  wire logic [3:0]          micro_a,
	input  wire logic [3:0]          micro_b,
	input  wire logic [3:0]          micro_d,
	input  wire logic [7:0]          micro_ctl,
	input  wire logic                wr_en,
	input  wire plr_pkg::plr_word_t  wr_data,
	input  wire logic                wide_wr,
	input  wire logic [31:0]         wide_data,
	input  wire logic                exp_wr,
	input  wire plr_pkg::plr_word_t  exp_data,
	input  wire logic                dshift_en,
	input  wire logic                dshift_left,
	input  wire logic                p_step,
	input  wire logic                p_branch,
	input  wire logic                jump_sub,
	input  wire plr_pkg::plr_word_t  branch_addr,
	input  wire logic                alu_upd,
	input  wire logic                alu_carry,
	input  wire logic                alu_ovf,
	input  wire logic                err_set,
	input  wire logic                tg_upd,
	input  wire logic                tg_in,
	input  wire logic                bop_en,
	input  wire logic [2:0]          bop_bit,
	input  wire logic                bop_val,
	input  wire logic                trr_en,
	input  wire plr_pkg::plr_word_t  ea_disp,
	input  wire logic                ea_use_b,
	input  wire logic                ea_use_x,
	input  wire logic                ea_indirect,
	input  wire logic                ea_post,
	input  wire plr_pkg::plr_word_t  ptr_in,
	input  wire plr_pkg::plr_word_t  mmu_addr_in,
	output plr_pkg::plr_word_t       rd_a,
	output plr_pkg::plr_word_t       rd_b,
	output logic [31:0]              acc_wide,
	output logic [47:0]              float_acc,
	output logic [7:0]               status_out,
	output logic [7:0]               cycle_ctl,
	output plr_pkg::plr_word_t       mem_addr,
	output logic                     alt_page_table_enable,
	output logic                     err_irq,
	output plr_pkg::plr_level_t      cur_level
);
	import plr_pkg::*;

	logic                 rst_meta;
	logic                 rst_n;
	plr_word_t            regs [`PLR_LEVELS][`PLR_SLOTS];
	logic [31:0]          ctrl;
	logic [3:0]           dbg_lvl;
	logic [3:0]           dbg_idx;
	logic [3:0]           sel_a;
	logic [3:0]           sel_b;
	logic [3:0]           sel_d;
	logic [7:0]           sts;
	logic [7:0]           next_sts;
	logic                 sts_touch;
	logic [31:0]          next_ad;
	logic                 shift_out;
	plr_word_t            val_a;
	plr_word_t            val_b;
	plr_word_t            cur_p;
	plr_word_t            next_logical;
	logic                 micro_busy;
	logic                 wr_go;
	logic                 rd_go;
	logic                 dbg_hit;
	logic [31:0]          rd_word;
	logic                 rd_ok;

	// Reset release through two flops
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// Field mapping of inter-register instructions
	assign sel_a = !ir_map ? micro_a
		: (instr_word[6] ? PLR_ZERO : {1'b0, instr_word[5:3]});
	assign sel_b = ir_map ? {1'b0, instr_word[2:0]} : micro_b;
	assign sel_d = ir_map ? {1'b0, instr_word[2:0]} : micro_d;

	// Operand selection within the current level's set
	always_comb
	begin
		val_a = (sel_a < 4'(`PLR_SLOTS)) ? regs[cur_level][sel_a] : 16'h0000;
		val_b = (sel_b < 4'(`PLR_SLOTS)) ? regs[cur_level][sel_b] : 16'h0000;
		cur_p = regs[cur_level][PLR_P];
		sts   = regs[cur_level][PLR_STS][7:0];
	end

	// Double length shift of A and D
	assign next_ad   = dshift_left
		? {regs[cur_level][PLR_A][14:0], regs[cur_level][PLR_D], sts[`PLR_IND_M]}
		: {sts[`PLR_IND_M], regs[cur_level][PLR_A], regs[cur_level][PLR_D][15:1]};
	assign shift_out = dshift_left ? regs[cur_level][PLR_A][15] : regs[cur_level][PLR_D][0];

	// Indicator update; hardware sets come after program clears
	always_comb
	begin
		next_sts  = sts;
		sts_touch = trr_en | bop_en | alu_upd | err_set | tg_upd | dshift_en;
		if (trr_en)
			next_sts = wr_data[7:0];
		if (bop_en)
			next_sts[bop_bit] = bop_val;
		if (alu_upd)
		begin
			next_sts[`PLR_IND_C] = alu_carry;
			next_sts[`PLR_IND_Q] = alu_ovf;
			if (alu_ovf)
				next_sts[`PLR_IND_O] = 1'b1;
		end
		if (err_set)
			next_sts[`PLR_IND_Z] = 1'b1;
		if (tg_upd)
			next_sts[`PLR_IND_TG] = tg_in;
		if (dshift_en)
			next_sts[`PLR_IND_M] = shift_out;
	end

	assign micro_busy = wr_en | wide_wr | exp_wr | dshift_en | p_step | p_branch | jump_sub
		| sts_touch;
	// Register block
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int l = 0; l < `PLR_LEVELS; l++)
				for (int s = 0; s < `PLR_SLOTS; s++)
					regs[l][s] <= 16'h0000;
		end
		else
		begin
			if (wr_en && sel_d < 4'(`PLR_SLOTS))
				regs[cur_level][sel_d] <= wr_data;
			if (wide_wr)
			begin
				regs[cur_level][PLR_A] <= wide_data[31:16];
				regs[cur_level][PLR_D] <= wide_data[15:0];
			end
			if (exp_wr)
				regs[cur_level][PLR_T] <= exp_data;
			if (dshift_en)
			begin
				regs[cur_level][PLR_A] <= next_ad[31:16];
				regs[cur_level][PLR_D] <= next_ad[15:0];
			end
			if (jump_sub)
			begin
				regs[cur_level][PLR_L] <= 16'(cur_p + 16'h0001);
				regs[cur_level][PLR_P] <= branch_addr;
			end
			else if (p_branch)
				regs[cur_level][PLR_P] <= branch_addr;
			else if (p_step)
				regs[cur_level][PLR_P] <= 16'(cur_p + 16'h0001);
			if (sts_touch)
				regs[cur_level][PLR_STS][7:0] <= next_sts;
			if (wr_go && dbg_hit && s_axi_awaddr == `PLR_OFF_DBG_DAT && dbg_idx < 4'(`PLR_SLOTS))
				regs[dbg_lvl][dbg_idx] <= s_axi_wdata[15:0];
		end
	end

	// Read ports, A and D, floating accumulator
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_a      <= 16'h0000;
			rd_b      <= 16'h0000;
			acc_wide  <= 32'h0000_0000;
			float_acc <= 48'h0000_0000_0000;
			cycle_ctl <= 8'h00;
		end
		else
		begin
			rd_a      <= val_a;
			rd_b      <= val_b;
			acc_wide  <= {regs[cur_level][PLR_A], regs[cur_level][PLR_D]};
			float_acc <= {regs[cur_level][PLR_T], regs[cur_level][PLR_A],
				regs[cur_level][PLR_D]};
			cycle_ctl <= micro_ctl;
		end
	end

	// Address formation: B before the pointer fetch, X after
	always_comb
	begin
		if (ea_indirect && ea_post)
			next_logical = 16'(ptr_in + (ea_use_x ? regs[cur_level][PLR_X] : 16'h0000));
		else
			next_logical = 16'(ea_disp + (ea_use_b ? regs[cur_level][PLR_B] : 16'h0000)
				+ ((ea_use_x && !ea_indirect) ? regs[cur_level][PLR_X] : 16'h0000));
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			mem_addr <= 16'h0000;
		else
			mem_addr <= ctrl[`PLR_CTRL_MMU] ? mmu_addr_in : next_logical;
	end
	// Indicator outputs
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			status_out            <= 8'h00;
			alt_page_table_enable <= 1'b0;
			err_irq               <= 1'b0;
		end
		else
		begin
			status_out            <= sts;
			alt_page_table_enable <= sts[`PLR_IND_PTM];
			err_irq               <= sts[`PLR_IND_Z] & ctrl[`PLR_CTRL_ERRIE];
		end
	end

	assign cur_level = ctrl[3:0];
	// Bus write path
	assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ~micro_busy;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign dbg_hit       = (s_axi_awaddr[1:0] == 2'b00);

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl         <= `PLR_CTRL_RESET;
			dbg_lvl      <= 4'h0;
			dbg_idx      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `PLR_RESP_OKAY;
		end
		else
		begin
			if (level_load)
				ctrl[3:0] <= level_in;
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `PLR_RESP_OKAY;
				if (!dbg_hit)
					s_axi_bresp <= `PLR_RESP_SLVERR;
				else if (s_axi_awaddr == `PLR_OFF_CTRL && s_axi_wstrb[0])
				begin
					if (!level_load)
						ctrl[3:0] <= s_axi_wdata[3:0];
					ctrl[`PLR_CTRL_MMU]   <= s_axi_wdata[`PLR_CTRL_MMU];
					ctrl[`PLR_CTRL_ERRIE] <= s_axi_wdata[`PLR_CTRL_ERRIE];
				end
				else if (s_axi_awaddr == `PLR_OFF_DBG_SEL && s_axi_wstrb[0])
				begin
					dbg_lvl <= s_axi_wdata[3:0];
					dbg_idx <= s_axi_wdata[7:4];
				end
				else if (s_axi_awaddr == `PLR_OFF_STATUS)
					s_axi_bresp <= `PLR_RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Bus read path
	assign rd_go         = s_axi_arvalid & ~s_axi_rvalid;
	assign s_axi_arready = rd_go;

	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_ok   = 1'b1;
		unique case (s_axi_araddr)
			`PLR_OFF_CTRL:    rd_word = {26'h0, ctrl[5:0]};
			`PLR_OFF_STATUS:  rd_word = {20'h0, cur_level, sts};
			`PLR_OFF_DBG_SEL: rd_word = {24'h0, dbg_idx, dbg_lvl};
			`PLR_OFF_DBG_DAT: rd_word = (dbg_idx < 4'(`PLR_SLOTS)) ?
				{16'h0, regs[dbg_lvl][dbg_idx]} : 32'h0000_0000;
			default:          rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `PLR_RESP_OKAY;
		end
		else if (rd_go)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_ok ? `PLR_RESP_OKAY : `PLR_RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule // plr_regfile
`default_nettype wire

// *** plr_regfile_sva.sv ***
/*
 Checker for the program level register file, bound to its ports.
 Assumes the micro strobes are single-cycle pulses on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module plr_regfile_sva
(
	input wire logic               mclk,
	input wire logic               nrst,
	input wire logic               level_load, wr_en, wide_wr, exp_wr, dshift_en,
	input wire logic               alu_upd, alu_carry, alu_ovf, err_set, tg_upd,
	input wire logic               bop_en, bop_val, trr_en, ir_map,
	input wire logic [2:0]         bop_bit,
	input wire logic [3:0]         micro_a,
	input wire logic [7:0]         status_out,
	input wire logic [31:0]        wide_data, acc_wide,
	input wire logic [47:0]        float_acc,
	input wire plr_pkg::plr_word_t exp_data, instr_word, rd_a,
	input wire plr_pkg::plr_level_t level_in, cur_level
);
	import plr_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// No indicator writer active
	sequence s_calm;
		!(trr_en || bop_en || alu_upd || err_set || tg_upd || dshift_en || level_load || wr_en);
	endsequence
	// No accumulator writer active
	sequence s_still;
		!(wr_en || wide_wr || exp_wr || dshift_en || level_load);
	endsequence
	property p_dyn;
		alu_upd && !level_load ##1 s_calm
		|=> status_out[6] == $past(alu_carry, 2) && status_out[4] == $past(alu_ovf, 2);
	endproperty
	property p_static;
		alu_upd && alu_ovf && !level_load ##1 s_calm |=> status_out[5];
	endproperty
	property p_err;
		err_set && !level_load ##1 s_calm |=> status_out[3];
	endproperty
	property p_bop;
		bop_en && bop_bit == 3'h2 && !level_load ##1 s_calm |=> status_out[2] == $past(bop_val, 2);
	endproperty
	property p_wide;
		wide_wr && !dshift_en && !level_load ##1 s_still |=> acc_wide == $past(wide_data, 2);
	endproperty
	property p_float;
		exp_wr && !level_load ##1 s_still |=> float_acc[47:32] == $past(exp_data, 2);
	endproperty
	property p_zero;
		(ir_map ? instr_word[6] : micro_a == 4'hf) |=> rd_a == 16'h0000;
	endproperty
	property p_level;
		level_load |=> cur_level == $past(level_in);
	endproperty
	a_dyn: assert property (p_dyn)
		else $error("dynamic indicators wrong");
	a_static: assert property (p_static)
		else $error("static overflow not set");
	a_err: assert property (p_err)
		else $error("error indicator not set");
	a_bop: assert property (p_bop)
		else $error("one bit accumulator wrong");
	a_wide: assert property (p_wide)
		else $error("double word wrong");
	a_float: assert property (p_float)
		else $error("exponent part wrong");
	a_zero: assert property (p_zero)
		else $error("zero source not zero");
	a_level: assert property (p_level)
		else $error("level not loaded");
endmodule // plr_regfile_sva
bind plr_regfile plr_regfile_sva i_sva (.*);
`default_nettype wire

// *** plr_micro_model.sv ***
/*
 Microprogram unit model driving the micro port of the register file.
 Assumes op is called by one process at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module plr_micro_model
(
	input wire logic           mclk,
	output logic               level_load, ir_map, wr_en, wide_wr, exp_wr, dshift_en,
	output logic               dshift_left, p_step, p_branch, jump_sub, alu_upd, alu_carry,
	output logic               alu_ovf, err_set, tg_upd, tg_in, bop_en, bop_val, trr_en,
	output logic               ea_use_b, ea_use_x, ea_indirect, ea_post,
	output logic [2:0]         bop_bit,
	output logic [3:0]         micro_a, micro_b, micro_d,
	output logic [7:0]         micro_ctl,
	output logic [31:0]        wide_data,
	output plr_pkg::plr_word_t instr_word, wr_data, exp_data, branch_addr,
	output plr_pkg::plr_word_t ea_disp, ptr_in, mmu_addr_in,
	output plr_pkg::plr_level_t level_in
);
	import plr_pkg::*;
	initial
	begin
		{level_load, ir_map, wr_en, wide_wr, exp_wr, dshift_en, dshift_left, p_step} = '0;
		{p_branch, jump_sub, alu_upd, alu_carry, alu_ovf, err_set, tg_upd, tg_in} = '0;
		{bop_en, bop_val, trr_en, ea_use_b, ea_use_x, ea_indirect, ea_post, bop_bit} = '0;
		{micro_a, micro_b, micro_d, micro_ctl, wide_data, level_in} = '0;
		{instr_word, wr_data, exp_data, branch_addr, ea_disp, ptr_in, mmu_addr_in} = '0;
	end
	// One micro operation, strobe high for one cycle
	task automatic op(input int k, input logic [31:0] v);
		@(posedge mclk);
		micro_ctl <= v[7:0];
		case (k)
			0: {wr_en, micro_d, wr_data} <= {1'h1, v[19:0]};
			1: {wide_wr, wide_data} <= {1'h1, v};
			2: {exp_wr, exp_data} <= {1'h1, v[15:0]};
			3: {dshift_en, dshift_left} <= {1'h1, v[0]};
			4: p_step <= 1'h1;
			5: {p_branch, branch_addr} <= {1'h1, v[15:0]};
			6: {jump_sub, branch_addr} <= {1'h1, v[15:0]};
			7: {alu_upd, alu_carry, alu_ovf} <= {1'h1, v[1:0]};
			8: err_set <= 1'h1;
			9: {tg_upd, tg_in} <= {1'h1, v[0]};
			10: {bop_en, bop_bit, bop_val} <= {1'h1, v[3:0]};
			11: {trr_en, wr_data} <= {1'h1, v[15:0]};
			12: {level_load, level_in} <= {1'h1, v[3:0]};
			13: {ptr_in, ea_disp} <= v;
			14: {ea_use_b, ea_use_x, ea_indirect, ea_post, mmu_addr_in} <= v[19:0];
			15: {ir_map, instr_word} <= {1'h1, v[15:0]};
			16: {micro_b, micro_a} <= v[7:0];
			default: ;
		endcase
		@(posedge mclk);
		{level_load, ir_map, wr_en, wide_wr, exp_wr, dshift_en, p_step, p_branch} <= '0;
		{jump_sub, alu_upd, err_set, tg_upd, bop_en, trr_en} <= '0;
		#1;
	endtask
endmodule // plr_micro_model
`default_nettype wire

// *** plr_regfile_test.sv ***
/*
 Testbench of the program level register file with the micro unit model.
 Assumes design, package, model and checker compile first.
*/
`timescale 1ns/1ps
`default_nettype none
module plr_regfile_test;
	import plr_pkg::*;
	logic        mclk = 1'h0;
	logic        nrst = 1'h0;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, wide_data, acc_wide, rv;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
	logic        level_load, ir_map, wr_en, wide_wr, exp_wr, dshift_en, dshift_left, p_step;
	logic        p_branch, jump_sub, alu_upd, alu_carry, alu_ovf, err_set, tg_upd, tg_in;
	logic        bop_en, bop_val, trr_en, ea_use_b, ea_use_x, ea_indirect, ea_post;
	logic        alt_page_table_enable, err_irq;
	logic [2:0]  bop_bit;
	logic [3:0]  micro_a, micro_b, micro_d;
	logic [7:0]  micro_ctl, cycle_ctl, status_out;
	logic [47:0] float_acc;
	plr_word_t   instr_word, wr_data, exp_data, branch_addr, ea_disp, ptr_in, mmu_addr_in;
	plr_word_t   rd_a, rd_b, mem_addr;
	plr_level_t  level_in, cur_level;
	int          failures = 0;
	int          tests_run = 0;
	plr_regfile i_dut (.*);
	plr_micro_model i_mp (.*);
	always #10 mclk = ~mclk;
	task automatic test_done(input int f);
		failures += f;
		$display("Comparisons %0d, failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [47:0] g, input logic [47:0] e);
		tests_run++;
		if (g !== e)
		begin
			failures++;
			$display("CHECK FAILED %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic tick;
		@(posedge mclk);
		#1;
	endtask
	// Bus write, response code left in rr
	task automatic axw(input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (n = 0; n < 40; n++)
		begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) break;
		end
		rr = s_axi_bresp;
		s_axi_bready <= 1'h0;
		if (n == 40) test_done(1);
	endtask
	// Bus read, data in rv and code in rr
	task automatic axr(input logic [3:0] a);
		int n;
		@(posedge mclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		for (n = 0; n < 40; n++)
		begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) break;
		end
		{rv, rr} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'h0;
		if (n == 40) test_done(1);
	endtask
	task automatic t_reset;
		chk(status_out, 8'h00);
		axr(4'h0);
		chk({rv, rr}, 34'h0);
		axw(4'h4, 32'hff);
		chk(rr, 2'h2);
		axw(4'h2, 32'h1);
		chk(rr, 2'h2);
	endtask
	task automatic t_dbg;
		axw(4'h8, 32'h9f);
		axr(4'hc);
		chk({rv, rr}, {32'h0000_f9a5, 2'h0});
		axw(4'hc, 32'h0000_5a5a);
		axr(4'hc);
		chk({rv, rr}, {32'h0000_5a5a, 2'h0});
		axw(4'h8, 32'h95);
		axr(4'hc);
		chk(rv, 32'h0000_0000);
		axw(4'h8, 32'ha5);
		axr(4'hc);
		chk(rv, 32'h0000_0000);
		axr(4'h8);
		chk({rv, rr}, {32'h0000_00a5, 2'h0});
	endtask
	task automatic t_sets;
		int lv, s;
		for (lv = 0; lv < 16; lv += 15)
		begin
			i_mp.op(12, lv);
			for (s = 1; s < 10; s++) i_mp.op(0, {s[3:0], lv[3:0], s[3:0], 8'ha5});
		end
		for (lv = 0; lv < 16; lv += 15)
		begin
			i_mp.op(12, lv);
			for (s = 1; s < 10; s++)
			begin
				i_mp.op(16, s);
				chk(rd_a, {lv[3:0], s[3:0], 8'ha5});
			end
		end
		i_mp.op(15, 32'h000a);
		chk({rd_a, rd_b}, 32'hf1a5_f2a5);
		i_mp.op(15, 32'h004a);
		chk(rd_a, 16'h0000);
		axw(4'h0, 32'h5);
		i_mp.op(16, 32'h1f);
		chk({cur_level, rd_a, rd_b}, 36'h5_0000_0000);
	endtask
	task automatic t_wide;
		i_mp.op(1, 32'h8000_0001);
		i_mp.op(2, 32'h4123);
		tick;
		chk(float_acc, 48'h4123_8000_0001);
		i_mp.op(3, 32'h1);
		tick;
		chk({status_out[7], acc_wide}, 33'h1_0000_0002);
		i_mp.op(3, 32'h0);
		tick;
		chk({status_out[7], acc_wide}, 33'h0_8000_0001);
	endtask
	task automatic t_pc;
		i_mp.op(0, 32'h7_0100);
		i_mp.op(4, 32'h0);
		i_mp.op(6, 32'h2000);
		i_mp.op(16, 32'h47);
		chk({rd_a, rd_b, cycle_ctl}, 40'h2000_0102_47);
		i_mp.op(5, 32'h3000);
		i_mp.op(4, 32'h0);
		i_mp.op(16, 32'h7);
		chk(rd_a, 16'h3001);
	endtask
	task automatic t_ind;
		axw(4'h0, 32'h25);
		i_mp.op(7, 32'h3);
		i_mp.op(7, 32'h0);
		i_mp.op(8, 32'h0);
		i_mp.op(10, 32'h5);
		i_mp.op(10, 32'h1);
		i_mp.op(9, 32'h1);
		tick;
		chk(status_out, 8'h2f);
		chk({alt_page_table_enable, err_irq}, 2'h3);
		axr(4'h4);
		chk(rv, 32'h52f);
		i_mp.op(11, 32'h90);
		tick;
		chk({status_out, err_irq}, 9'h120);
	endtask
	task automatic t_addr;
		i_mp.op(0, 32'h6_0100);
		i_mp.op(0, 32'h5_0010);
		i_mp.op(13, 32'h0400_0020);
		i_mp.op(14, 32'hc_7000);
		chk(mem_addr, 16'h0130);
		i_mp.op(14, 32'h7_7000);
		chk(mem_addr, 16'h0410);
		i_mp.op(14, 32'ha_7000);
		chk(mem_addr, 16'h0120);
		axw(4'h0, 32'h15);
		tick;
		chk(mem_addr, 16'h7000);
	endtask
	initial
	begin
		repeat (12) @(posedge mclk);
		nrst <= 1'h1;
		repeat (3) @(posedge mclk);
		t_reset;
		t_sets;
		t_wide;
		t_pc;
		t_ind;
		t_addr;
		t_dbg;
		test_done(0);
	end
endmodule // plr_regfile_test
`default_nettype wire
